// file: rtl/timer16_wave.sv
/*
  16-bit timer/counter with waveform mode and compare-output control.
  Assumes a single system clock, synchronous pin inputs and a plain
  register port whose read data appear one cycle after the read strobe.
*/
// Decided for this implementation: strobed register access.
//
// Notes on behaviour
// - Counter runs on clk, tick is an enable
// - Phase-frequency modes load compares at BOTTOM
// - BOTTOM timing mirrors TOP timing
// - Channel A action bits 7:6, B bits 5:4
// - Nonzero action overrides pin, except PWM action 01 without mode bit3; direction enables driver
// - Non-PWM: disconnect, toggle, clear, set on match
// - Fast PWM: non-inverting and inverting outputs
// - PWM action 01 toggles A only if mode bit3
// - Fast PWM: compare at TOP ignored by actions 10 and 11
// - Dual slope: clear up, set down
// - Mode from control A 1:0 and B 4:3
// - Mode 0: TOP 0xffff, immediate, overflow MAX
// - CLEAR_ON_MATCH_MODE modes 4, 12: immediate, overflow MAX
// - Phase correct: load at TOP, overflow BOTTOM
// - Fast PWM: load and overflow at TOP
// - Modes 8, 9: load and overflow at BOTTOM
// - Dual slope extremes hold output steady
// - Clock select: stop, prescaled or external edge
`include "timer16_params.svh"

module timer16_wave #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [COUNT_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [COUNT_W-1:0] reg_rdata,
  // External count source
  input wire logic ext_clk_pin,
  // Normal port function of the two waveform pins
  input wire logic port_out_a,
  input wire logic port_dir_a,
  input wire logic port_out_b,
  input wire logic port_dir_b,
  // Waveform pins
  output logic pin_a_o,
  output logic pin_a_oe,
  output logic pin_b_o,
  output logic pin_b_oe,
  // Interrupt
  output logic irq
);

  if (COUNT_W != 16) begin : g_width_check
    $error("timer16_wave supports only a 16-bit counter");
  end

  // Software-visible state
  logic [7:0] control_a_q, control_a_d, control_b_q, control_b_d;
  logic [COUNT_W-1:0] count_q, count_d, buf_a_q, buf_a_d, buf_b_q, buf_b_d;
  logic [COUNT_W-1:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d, capture_q, capture_d;
  logic [2:0] status_q, status_d, mask_q, mask_d;
  logic [COUNT_W-1:0] rdata_q, rdata_d;
  // Counter state
  logic down_q, down_d, block_q, block_d;
  // Prescaler state
  logic [`PRESC_BITS-1:0] presc_q, presc_d;
  logic ext_prev_q;

  // Decoded fields
  logic [3:0] waveform_mode;
  logic [1:0] waveform_mode_low, waveform_mode_high, chan_a_output_action, chan_b_output_action;
  timer16_pkg::clock_select_t clock_select;
  timer16_pkg::mode_kind_t kind;
  logic [COUNT_W-1:0] top;
  logic immediate_load, pwm_off, timer_tick_enable;
  logic at_top, at_bottom, at_max, load_event, ovf_event, wrap_event, match_a, match_b, wr_count;

  compare_ch_if ch_a ();
  compare_ch_if ch_b ();

  assign chan_a_output_action = control_a_q[`CA_ACT_A_HI:`CA_ACT_A_LO];
  assign chan_b_output_action = control_a_q[`CA_ACT_B_HI:`CA_ACT_B_LO];
  assign waveform_mode_low = control_a_q[`CA_MODE_HI:`CA_MODE_LO];
  assign waveform_mode_high = control_b_q[`CB_MODE_HI:`CB_MODE_LO];
  assign waveform_mode = {waveform_mode_high, waveform_mode_low};
  assign clock_select = timer16_pkg::clock_select_t'(control_b_q[`CB_CS_HI:`CB_CS_LO]);

  // Counting scheme and TOP source per mode; reserved mode 13 counts as normal
  always_comb begin
    kind = timer16_pkg::KIND_NORMAL;
    top = `TOP_MAX;
    unique case (waveform_mode)
      4'h1: begin kind = timer16_pkg::KIND_PC; top = `TOP_8BIT; end
      4'h2: begin kind = timer16_pkg::KIND_PC; top = `TOP_9BIT; end
      4'h3: begin kind = timer16_pkg::KIND_PC; top = `TOP_10BIT; end
      4'h4: begin kind = timer16_pkg::KIND_CTC; top = cmp_a_q; end
      4'h5: begin kind = timer16_pkg::KIND_FAST; top = `TOP_8BIT; end
      4'h6: begin kind = timer16_pkg::KIND_FAST; top = `TOP_9BIT; end
      4'h7: begin kind = timer16_pkg::KIND_FAST; top = `TOP_10BIT; end
      4'h8: begin kind = timer16_pkg::KIND_PFC; top = capture_q; end
      4'h9: begin kind = timer16_pkg::KIND_PFC; top = cmp_a_q; end
      4'ha: begin kind = timer16_pkg::KIND_PC; top = capture_q; end
      4'hb: begin kind = timer16_pkg::KIND_PC; top = cmp_a_q; end
      4'hc: begin kind = timer16_pkg::KIND_CTC; top = capture_q; end
      4'he: begin kind = timer16_pkg::KIND_FAST; top = capture_q; end
      4'hf: begin kind = timer16_pkg::KIND_FAST; top = cmp_a_q; end
      default: begin kind = timer16_pkg::KIND_NORMAL; top = `TOP_MAX; end
    endcase
  end

  assign immediate_load = (kind == timer16_pkg::KIND_NORMAL) || (kind == timer16_pkg::KIND_CTC);

  // Tick selection; the tick is an enable, never a clock
  always_comb begin
    unique case (clock_select)
      timer16_pkg::CS_STOP: timer_tick_enable = 1'b0;
      timer16_pkg::CS_DIV1: timer_tick_enable = 1'b1;
      timer16_pkg::CS_DIV8: timer_tick_enable = &presc_q[`DIV8_BITS-1:0];
      timer16_pkg::CS_DIV64: timer_tick_enable = &presc_q[`DIV64_BITS-1:0];
      timer16_pkg::CS_DIV256: timer_tick_enable = &presc_q[`DIV256_BITS-1:0];
      timer16_pkg::CS_DIV1024: timer_tick_enable = &presc_q;
      timer16_pkg::CS_EXT_FALL: timer_tick_enable = ext_prev_q & ~ext_clk_pin;
      timer16_pkg::CS_EXT_RISE: timer_tick_enable = ~ext_prev_q & ext_clk_pin;
    endcase
  end

  // Free-running prescaler; shared taps keep every divider in phase
  always_comb begin
    presc_d = presc_q + `PRESC_BITS'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc_q <= '0;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      ext_prev_q <= ext_clk_pin;
    end
  end

  // Events on the tick; BOTTOM+1 plays the part of TOP-1 in the dual slope
  assign at_top = timer_tick_enable && (count_q >= top);
  assign at_bottom = timer_tick_enable && (count_q == '0);
  assign at_max = timer_tick_enable && (count_q == `TOP_MAX);
  assign wrap_event = (kind == timer16_pkg::KIND_FAST) && at_top;
  always_comb begin
    unique case (kind)
      timer16_pkg::KIND_PC: begin
        load_event = at_top && !down_q;
        ovf_event = at_bottom && down_q;
      end
      timer16_pkg::KIND_PFC: begin
        load_event = at_bottom && down_q;
        ovf_event = at_bottom && down_q;
      end
      timer16_pkg::KIND_FAST: begin
        load_event = wrap_event;
        ovf_event = at_top;
      end
      default: begin
        load_event = 1'b0;
        ovf_event = at_max;
      end
    endcase
  end

  // A count write suppresses the match on the following tick
  assign match_a = timer_tick_enable && !block_q && (count_q == cmp_a_q);
  assign match_b = timer_tick_enable && !block_q && (count_q == cmp_b_q);
  assign wr_count = reg_wr && (reg_addr == `OFS_COUNT);

  // Counter next value and direction
  always_comb begin
    count_d = count_q;
    down_d = down_q;
    block_d = block_q;
    if (timer_tick_enable) begin
      block_d = 1'b0;
      unique case (kind)
        timer16_pkg::KIND_CTC, timer16_pkg::KIND_FAST: begin
          count_d = (count_q >= top) ? '0 : count_q + COUNT_W'(1);
        end
        timer16_pkg::KIND_PC, timer16_pkg::KIND_PFC: begin
          if (!down_q && count_q >= top) begin
            down_d = 1'b1;
            count_d = count_q - COUNT_W'(1);
          end else if (down_q && count_q == '0) begin
            down_d = 1'b0;
            count_d = COUNT_W'(1);
          end else begin
            count_d = down_q ? count_q - COUNT_W'(1) : count_q + COUNT_W'(1);
          end
        end
        default: count_d = count_q + COUNT_W'(1);
      endcase
    end
    if (kind != timer16_pkg::KIND_PC && kind != timer16_pkg::KIND_PFC) begin
      down_d = 1'b0;
    end
    // Software write wins over the tick
    if (wr_count) begin
      count_d = reg_wdata;
      block_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
      down_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      down_q <= down_d;
      block_q <= block_d;
    end
  end

  // Registers written by software, compare double buffering
  always_comb begin
    control_a_d = control_a_q;
    control_b_d = control_b_q;
    buf_a_d = buf_a_q;
    buf_b_d = buf_b_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    capture_d = capture_q;
    mask_d = mask_q;
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_CONTROL_A: control_a_d = reg_wdata[7:0];
        `OFS_CONTROL_B: control_b_d = reg_wdata[7:0] & `CB_WRITE_MASK;
        `OFS_COMPARE_A: buf_a_d = reg_wdata;
        `OFS_COMPARE_B: buf_b_d = reg_wdata;
        `OFS_CAPTURE: capture_d = reg_wdata;
        `OFS_IRQ_MASK: mask_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    // Immediate modes pass the buffer straight through
    if (immediate_load) begin
      cmp_a_d = buf_a_d;
      cmp_b_d = buf_b_d;
    end else if (load_event) begin
      cmp_a_d = buf_a_q;
      cmp_b_d = buf_b_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control_a_q <= `CONTROL_A_RESET;
      control_b_q <= `CONTROL_B_RESET;
      buf_a_q <= '0;
      buf_b_q <= '0;
      cmp_a_q <= '0;
      cmp_b_q <= '0;
      capture_q <= '0;
      mask_q <= '0;
    end else begin
      control_a_q <= control_a_d;
      control_b_q <= control_b_d;
      buf_a_q <= buf_a_d;
      buf_b_q <= buf_b_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      capture_q <= capture_d;
      mask_q <= mask_d;
    end
  end

  // Sticky status: write one to clear, a new event in that cycle wins
  always_comb begin
    status_d = status_q;
    if (reg_wr && reg_addr == `OFS_IRQ_STATUS) begin
      status_d = status_q & ~reg_wdata[2:0];
    end
    if (ovf_event) begin
      status_d[`IRQ_OVF] = 1'b1;
    end
    if (match_a) begin
      status_d[`IRQ_MATCH_A] = 1'b1;
    end
    if (match_b) begin
      status_d[`IRQ_MATCH_B] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);

  // Read mux; software sees the buffered compare values
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CONTROL_A: rdata_d = {8'h00, control_a_q};
        `OFS_CONTROL_B: rdata_d = {8'h00, control_b_q};
        `OFS_COUNT: rdata_d = count_q;
        `OFS_COMPARE_A: rdata_d = buf_a_q;
        `OFS_COMPARE_B: rdata_d = buf_b_q;
        `OFS_CAPTURE: rdata_d = capture_q;
        `OFS_IRQ_STATUS: rdata_d = {13'h0000, status_q};
        `OFS_IRQ_MASK: rdata_d = {13'h0000, mask_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Channel links
  assign ch_a.kind = kind;
  assign ch_a.tick = timer_tick_enable;
  assign ch_a.match = match_a;
  assign ch_a.wrap = wrap_event;
  assign ch_a.count_down = down_q;
  assign ch_a.action = chan_a_output_action;
  assign ch_a.mode_hi = waveform_mode[3];
  assign ch_a.cmp_is_top = (cmp_a_q == top);
  assign ch_a.cmp_is_bottom = (cmp_a_q == '0);
  assign ch_b.kind = kind;
  assign ch_b.tick = timer_tick_enable;
  assign ch_b.match = match_b;
  assign ch_b.wrap = wrap_event;
  assign ch_b.count_down = down_q;
  assign ch_b.action = chan_b_output_action;
  assign ch_b.mode_hi = waveform_mode[3];
  assign ch_b.cmp_is_top = (cmp_b_q == top);
  assign ch_b.cmp_is_bottom = (cmp_b_q == '0);

  // Channel B cannot toggle in PWM modes; its setting there is reserved
  wave_channel #(.TOGGLE_CAPABLE(1'b1)) u_chan_a (.clk(clk), .reset(reset), .ch(ch_a));
  wave_channel #(.TOGGLE_CAPABLE(1'b0)) u_chan_b (.clk(clk), .reset(reset), .ch(ch_b));

  // Pin override; PWM action 01 without mode bit 3 keeps the port function
  assign pwm_off = !immediate_load && !waveform_mode[3];
  assign pin_a_o = (chan_a_output_action[1] || (chan_a_output_action[0] && !pwm_off)) ? ch_a.wave : port_out_a;
  assign pin_a_oe = port_dir_a;
  assign pin_b_o = (chan_b_output_action[1] || (chan_b_output_action[0] && !pwm_off)) ? ch_b.wave : port_out_b;
  assign pin_b_oe = port_dir_b;

endmodule : timer16_wave

// file: common/timer16_params.svh
/*
  Offsets, field positions, reset values and fixed counts for the 16-bit
  waveform timer. Assumes an 8-bit register address on a plain strobe port.
*/
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// Register offsets
`define OFS_CONTROL_B 8'h2e
`define OFS_CONTROL_A 8'h2f
`define OFS_COUNT 8'h2c
`define OFS_COMPARE_A 8'h2a
`define OFS_COMPARE_B 8'h28
`define OFS_CAPTURE 8'h26
`define OFS_IRQ_STATUS 8'h25
`define OFS_IRQ_MASK 8'h24

// Control A fields
`define CA_ACT_A_HI 7
`define CA_ACT_A_LO 6
`define CA_ACT_B_HI 5
`define CA_ACT_B_LO 4
`define CA_MODE_HI 1
`define CA_MODE_LO 0

// Control B fields; bit 5 is reserved and reads zero
`define CB_MODE_HI 4
`define CB_MODE_LO 3
`define CB_CS_HI 2
`define CB_CS_LO 0
`define CB_WRITE_MASK 8'hdf

// Interrupt status and mask bits
`define IRQ_OVF 0
`define IRQ_MATCH_A 1
`define IRQ_MATCH_B 2

// Reset values
`define CONTROL_A_RESET 8'h00
`define CONTROL_B_RESET 8'h00

// Fixed TOP values and prescaler taps
`define TOP_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define PRESC_BITS 10
`define DIV8_BITS 3
`define DIV64_BITS 6
`define DIV256_BITS 8

`endif

// file: common/timer16_pkg.sv
/*
  Types shared by the waveform timer and its compare channels.
  Assumes the params header for all numeric constants.
*/
package timer16_pkg;

  // Counting scheme derived from the 4-bit waveform mode
  typedef enum logic [4:0] {
    KIND_NORMAL = 5'h01,
    KIND_CTC = 5'h02,
    KIND_PC = 5'h04,
    KIND_PFC = 5'h08,
    KIND_FAST = 5'h10
  } mode_kind_t;

  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clock_select_t;

endpackage : timer16_pkg

// file: common/compare_ch_if.sv
/*
  Link between the timer core and one compare channel.
  Assumes all pulses are qualified by the timer tick in the core.
*/
interface compare_ch_if;
  timer16_pkg::mode_kind_t kind;
  logic tick;
  logic match;
  logic wrap;
  logic count_down;
  logic [1:0] action;
  logic mode_hi;
  logic cmp_is_top;
  logic cmp_is_bottom;
  logic wave;

  modport ctrl (output kind, tick, match, wrap, count_down, action, mode_hi, cmp_is_top, cmp_is_bottom,
                input wave);
  modport chan (input kind, tick, match, wrap, count_down, action, mode_hi, cmp_is_top, cmp_is_bottom,
                output wave);
endinterface : compare_ch_if

// file: rtl/wave_channel.sv
/*
  One compare-output channel: holds the waveform register and applies the
  selected action. Assumes match and wrap are one-cycle pulses on a tick.
*/
module wave_channel #(
  parameter bit TOGGLE_CAPABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Core link
  compare_ch_if.chan ch
);

  logic wave_q;
  logic wave_d;

  // Next waveform level per counting scheme
  always_comb begin
    wave_d = wave_q;
    unique case (ch.kind)
      timer16_pkg::KIND_NORMAL, timer16_pkg::KIND_CTC: begin
        if (ch.match) begin
          unique case (ch.action)
            2'b01: wave_d = ~wave_q;
            2'b10: wave_d = 1'b0;
            2'b11: wave_d = 1'b1;
            default: wave_d = wave_q;
          endcase
        end
      end
      timer16_pkg::KIND_FAST: begin
        if (ch.action[1]) begin
          // Bottom action wins over a match at TOP when both fall on one tick
          if (ch.match && !ch.cmp_is_top) begin
            wave_d = ch.action[0];
          end else if (ch.wrap) begin
            wave_d = ~ch.action[0];
          end
        end else if (ch.action[0] && ch.mode_hi && TOGGLE_CAPABLE && ch.match) begin
          wave_d = ~wave_q;
        end
      end
      default: begin
        if (ch.action[1] && ch.tick) begin
          // Extremes pin the level so no glitch pulse appears
          if (ch.cmp_is_bottom) begin
            wave_d = ch.action[0];
          end else if (ch.cmp_is_top) begin
            wave_d = ~ch.action[0];
          end else if (ch.match) begin
            wave_d = ch.count_down ? ~ch.action[0] : ch.action[0];
          end
        end else if (ch.action == 2'b01 && ch.mode_hi && TOGGLE_CAPABLE && ch.match) begin
          wave_d = ~wave_q;
        end
      end
    endcase
  end

  // Waveform register, low after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  assign ch.wave = wave_q;

endmodule : wave_channel

// file: tb/timer16_wave_checker.sv
/*
  Port-level assertions for the waveform timer.
  Assumes the top-level ports of timer16_wave and the map of the params header.
*/
`include "timer16_params.svh"

module timer16_wave_checker #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [COUNT_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [COUNT_W-1:0] reg_rdata,
  // Port function and pins
  input wire logic port_out_a,
  input wire logic port_dir_a,
  input wire logic port_out_b,
  input wire logic port_dir_b,
  input wire logic pin_a_o,
  input wire logic pin_a_oe,
  input wire logic pin_b_o,
  input wire logic pin_b_oe,
  // Interrupt
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_a_q, ctl_a_d, ctl_b_q, ctl_b_d, mask_q, mask_d;

  // Shadows of software writes, so pin and readback rules can be judged
  assign ctl_a_d = (reg_wr && reg_addr == `OFS_CONTROL_A) ? reg_wdata[7:0] : ctl_a_q;
  assign ctl_b_d = (reg_wr && reg_addr == `OFS_CONTROL_B) ? reg_wdata[7:0] : ctl_b_q;
  assign mask_d = (reg_wr && reg_addr == `OFS_IRQ_MASK) ? reg_wdata[7:0] : mask_q;

  // Shadow registers cleared with the design
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
      mask_q <= 8'h00;
    end else begin
      ctl_a_q <= ctl_a_d;
      ctl_b_q <= ctl_b_d;
      mask_q <= mask_d;
    end
  end

  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (reset);

  a_oe_follows_a: assert property (pin_a_oe == port_dir_a)
    else $error("pin A enable differs from direction");
  a_oe_follows_b: assert property (pin_b_oe == port_dir_b)
    else $error("pin B enable differs from direction");
  a_idle_pin_a: assert property (ctl_a_q[7:6] == 2'b00 |-> pin_a_o == port_out_a)
    else $error("pin A not in port function with action zero");
  a_idle_pin_b: assert property (ctl_a_q[5:4] == 2'b00 |-> pin_b_o == port_out_b)
    else $error("pin B not in port function with action zero");
  a_toggle_off: assert property ((ctl_a_q[7:6] == 2'b01 && !ctl_b_q[4] && ctl_a_q[1:0] != 2'b00)
    |-> pin_a_o == port_out_a) else $error("pin A not disconnected for action one in PWM");
  a_ctl_a_read: assert property (reg_rd && reg_addr == `OFS_CONTROL_A |=> reg_rdata == {8'h00, ctl_a_q})
    else $error("control A read differs from last write");
  a_ctl_b_read: assert property (reg_rd && reg_addr == `OFS_CONTROL_B
    |=> reg_rdata == {8'h00, ctl_b_q & `CB_WRITE_MASK}) else $error("control B read differs from last write");
  a_reset_quiet: assert property ($past(reset) |-> !irq && pin_a_o == port_out_a && pin_b_o == port_out_b)
    else $error("outputs not quiet after reset");
  a_mask_gate: assert property (mask_q[2:0] == 3'h0 |-> !irq)
    else $error("interrupt high with all sources masked");
  a_read_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside the read answer cycle");
endmodule : timer16_wave_checker

bind timer16_wave timer16_wave_checker #(.COUNT_W(COUNT_W)) checker_u (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_out_a(port_out_a), .port_dir_a(port_dir_a), .port_out_b(port_out_b), .port_dir_b(port_dir_b),
  .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .irq(irq));

// file: tb/pin_pad.sv
/*
  Board-side model of one waveform pin.
  Assumes the last driven level is all the history a floating pin needs.
*/
module pin_pad (
  // Clock
  input wire logic clk,
  // Drive from the timer
  input wire logic drv,
  input wire logic drv_en,
  // Level seen on the board
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;

  // Remember the driven level while the driver is on
  always @(posedge clk) begin
    if (drv_en) last_q <= drv;
  end
  // Floating pin shows the inverse, never a lucky match
  assign level = drv_en ? drv : ~last_q;
endmodule : pin_pad

// file: tb/tb.sv
/*
  Self-checking bench: register map, count rates, waveform duty in every
  counting scheme except normal, overflow interrupt. Assumes the bound checker.
*/
`include "timer16_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] m; logic [15:0] top; logic [15:0] cmp; logic [1:0] act;} pwm_case_t;
  localparam pwm_case_t CASES [14] = '{'{4'h4, 16'h0009, 16'h0009, 2'b01}, '{4'h4, 16'h0009, 16'h0009, 2'b10},
    '{4'hc, 16'h0013, 16'h0005, 2'b11}, '{4'h5, 16'h00ff, 16'h0003, 2'b10}, '{4'h5, 16'h00ff, 16'h00ff, 2'b10},
    '{4'h6, 16'h01ff, 16'h00ff, 2'b11}, '{4'h7, 16'h03ff, 16'h03ff, 2'b11}, '{4'he, 16'h003f, 16'h0010, 2'b01},
    '{4'hf, 16'h0050, 16'h0050, 2'b10}, '{4'h1, 16'h00ff, 16'h0000, 2'b10}, '{4'h2, 16'h01ff, 16'h01ff, 2'b10},
    '{4'h8, 16'h007f, 16'h0020, 2'b10}, '{4'h9, 16'h0060, 16'h0060, 2'b11}, '{4'ha, 16'h0050, 16'h0000, 2'b11}};
  localparam logic [15:0] RATE [8] = '{16'h0000, 16'h0800, 16'h0100, 16'h0020, 16'h0008, 16'h0002, 16'h0008,
    16'h0008};
  logic clk, reset, reg_wr, reg_rd, ext_clk_pin, irq, pad_a, pad_b;
  logic port_out_a, port_dir_a, port_out_b, port_dir_b, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_q, d, base, p, cmp_b, ha, hb;
  logic [31:0] lfsr_q;
  pwm_case_t c;
  int num_errors, total_checks;

  timer16_wave #(.COUNT_W(16)) dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin), .port_out_a(port_out_a),
    .port_dir_a(port_dir_a), .port_out_b(port_out_b), .port_dir_b(port_dir_b), .pin_a_o(pin_a_o),
    .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .irq(irq));
  pin_pad pad_a_u (.clk(clk), .drv(pin_a_o), .drv_en(pin_a_oe), .level(pad_a));
  pin_pad pad_b_u (.clk(clk), .drv(pin_b_o), .drv_en(pin_b_oe), .level(pad_b));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction : lfsr_next

  // Random port values every cycle, so any slip in the pin override shows
  always @(posedge clk) begin
    lfsr_q <= lfsr_next(lfsr_q);
    port_out_a <= lfsr_q[3];
    port_out_b <= lfsr_q[7];
  end

  function automatic logic is_dual(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  endfunction : is_dual

  // High cycles over two periods
  function automatic logic [15:0] exp_hi(input logic [3:0] m, input logic [15:0] per, input logic [15:0] cmp,
                                         input logic [1:0] act);
    logic [15:0] hi;
    if (act == 2'b01) return per;
    if (m == 4'h4 || m == 4'hc) hi = 16'h0000;
    else hi = is_dual(m) ? cmp << 1 : cmp + 16'h0001;
    return (act[0] ? per - hi : hi) << 1;
  endfunction : exp_hi

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask : rd

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Watchdog, about twice the expected run
  initial begin
    #700000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    lfsr_q = 32'h0c2f3c7d;
    {reset, reg_wr, reg_rd, ext_clk_pin, port_dir_b} = 5'h10;
    port_dir_a = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_CONTROL_A);
    check(rd_q, 16'h0000, "control a reset");
    // Random readback, reserved bit forced on
    repeat (6) begin
      d = lfsr_q[15:0];
      wr(`OFS_CONTROL_A, d);
      rd(`OFS_CONTROL_A);
      check(rd_q, {8'h00, d[7:0]}, "control a");
      wr(`OFS_CONTROL_B, d | 16'h0020);
      rd(`OFS_CONTROL_B);
      check(rd_q, {8'h00, d[7:0] & `CB_WRITE_MASK}, "control b");
    end
    rd(8'h00);
    check(rd_q, 16'h0000, "unmapped read");
    wr(`OFS_CONTROL_A, 16'h0000);
    // Count rate of every clock source over 2048 cycles
    for (int cs = 0; cs < 8; cs++) begin
      wr(`OFS_CONTROL_B, 16'h0000);
      wr(`OFS_COUNT, 16'h0000);
      wr(`OFS_CONTROL_B, 16'(cs));
      rd(`OFS_COUNT);
      base = rd_q;
      repeat (8) @(posedge clk);
      repeat (8) begin
        ext_clk_pin <= 1'b1;
        repeat (2) @(posedge clk);
        ext_clk_pin <= 1'b0;
        repeat (2) @(posedge clk);
      end
      repeat (2006) @(posedge clk);
      rd(`OFS_COUNT);
      check(rd_q - base, RATE[cs], "count rate");
    end
    // Duty of both channels per case, only A for action 01 in mode 14; compare B random below TOP
    port_dir_b <= 1'b1;
    foreach (CASES[i]) begin
      c = CASES[i];
      cmp_b = lfsr_q[15:0] % c.top;
      p = is_dual(c.m) ? c.top << 1 : c.top + 16'h0001;
      wr(`OFS_CONTROL_B, 16'h0000);
      wr(`OFS_CONTROL_A, 16'h0000);
      wr(`OFS_CAPTURE, c.top);
      wr(`OFS_COMPARE_A, c.cmp);
      wr(`OFS_COMPARE_B, cmp_b);
      wr(`OFS_COUNT, 16'h0000);
      wr(`OFS_CONTROL_A, {8'h00, c.act, c.act, 2'b00, c.m[1:0]});
      wr(`OFS_CONTROL_B, {11'h000, c.m[3:2], 3'h1});
      repeat (2 * p) @(posedge clk);
      {ha, hb} = 32'h00000000;
      repeat (2 * p) begin
        @(posedge clk);
        #1;
        ha = ha + {15'h0000, pad_a};
        hb = hb + {15'h0000, pad_b};
      end
      check(ha, exp_hi(c.m, p, c.cmp, c.act), "duty a");
      if (c.act != 2'b01 || c.m == 4'h4) check(hb, exp_hi(c.m, p, cmp_b, c.act), "duty b");
    end
    // Overflow at MAX in normal mode, masked, unmasked, cleared
    wr(`OFS_CONTROL_B, 16'h0000);
    wr(`OFS_CONTROL_A, 16'h0000);
    wr(`OFS_IRQ_STATUS, 16'h0007);
    wr(`OFS_COUNT, 16'hfff0);
    wr(`OFS_CONTROL_B, 16'h0001);
    repeat (30) @(posedge clk);
    wr(`OFS_CONTROL_B, 16'h0000);
    rd(`OFS_IRQ_STATUS);
    check(rd_q & 16'h0001, 16'h0001, "overflow flag");
    check({15'h0000, irq}, 16'h0000, "irq masked");
    wr(`OFS_IRQ_MASK, 16'h0001);
    #1;
    check({15'h0000, irq}, 16'h0001, "irq raised");
    wr(`OFS_IRQ_STATUS, 16'h0001);
    #1;
    check({15'h0000, irq}, 16'h0000, "irq cleared");
    // Second reset; A kept in port function by PWM action 01, B active
    wr(`OFS_CONTROL_A, 16'h0071);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_CONTROL_A);
    check(rd_q, 16'h0000, "control a after reset");
    summarize();
  end
endmodule : tb
